// >>> apd_pkg.sv
// Package for the audio clock divider configuration block.
// Assumes a host-side register write port delivering 16-bit words.
`default_nettype none
package apd_pkg;
    localparam logic [7:0]  ADDR_PLL_DIV   = 8'h1b;
    localparam logic [7:0]  ADDR_PLL_FRAC  = 8'h1c;
    localparam logic [7:0]  ADDR_DAC_RAMP  = 8'h1d;
    localparam logic [0:0]  RST_PLL_ON     = 1'h0;
    localparam logic [3:0]  RST_BYPASS     = 4'h2;
    localparam logic [2:0]  RST_PRE        = 3'h0;
    localparam logic [5:0]  RST_INT        = 6'h01;
    localparam logic [13:0] RST_FRAC       = 14'h0000;
    localparam logic [13:0] FRAC_LIMIT     = 14'h270f;
    localparam logic [0:0]  RST_SOFT_DIS   = 1'h0;
    localparam logic [1:0]  RSVD_LOW       = 2'h0;
    localparam int          POS_SOFT_DIS   = 14;
    localparam logic [4:0]  DIV16          = 5'h10;
    localparam logic [3:0]  DIV8           = 4'h8;

    typedef struct packed {
        logic       pll_on_bit;
        logic [3:0] bypass_divider;
        logic [2:0] pre_divider;
        logic [5:0] integer_multiplier;
        logic [1:0] reserved;
    } apd_div_t;

    typedef struct packed {
        logic       pll_on;
        logic [4:0] bypass_ratio;
        logic [3:0] pre_ratio;
        logic [5:0] int_mult;
        logic [13:0] frac_mult;
        logic       soft_step_disable;
    } apd_cfg_t;
endpackage : apd_pkg
`default_nettype wire

// >>> apd_regs.sv
// Register store for the three configuration words.
// Assumes write strobes come from logic on the same clock.
`default_nettype none
module apd_regs
    import apd_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr_div,
    input  wire logic        i_wr_frac,
    input  wire logic        i_wr_ramp,
    input  wire logic [15:0] i_wdata,
    output var  apd_div_t    o_div,
    output var  logic [13:0] o_frac,
    output var  logic        o_soft_dis
);
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_div      <= '{RST_PLL_ON, RST_BYPASS, RST_PRE, RST_INT, RSVD_LOW};
            o_frac     <= RST_FRAC;
            o_soft_dis <= RST_SOFT_DIS;
        end else begin
            if (i_wr_div) begin
                o_div <= '{i_wdata[15], i_wdata[14:11], i_wdata[10:8], i_wdata[7:2], RSVD_LOW};
            end
            if (i_wr_frac) begin
                o_frac <= i_wdata[15:2];
            end
            if (i_wr_ramp) begin
                o_soft_dis <= i_wdata[POS_SOFT_DIS];
            end
        end
    end
endmodule : apd_regs
`default_nettype wire

// >>> apd_top.sv
// Audio clock divider configuration: register file and effective divider values.
// Assumes the serial port decoder delivers whole 16-bit writes and reads on i_sys_clk.
//
// Functional notes
// - PLL off when divider register top bit is 0, on when 1; resets 0.
// - Bypass divider used only with PLL off; 0 means 16; resets 0010.
// - Pre-divider used only with PLL on; 0 means 8; resets 000.
// - Integer multiplier used only with PLL on, value direct 1..63; resets 1.
// - Fraction multiplier in upper 14 bits, used only with PLL on; resets 0.
// - Fraction values above 9999 are used as 9999.
// - Two lowest bits of PLL registers read 00; host writes 00.
// - Soft-step disable bit: 0 enables stepping, 1 disables; resets 0.
`default_nettype none
module apd_top
    import apd_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    output var apd_cfg_t     o_cfg
);
    ////////////////////////////////////////////////////////////////////////////
    apd_div_t    div_reg;
    logic [13:0] frac_reg;
    logic        soft_dis;

    wire logic hit_div  = (i_addr == ADDR_PLL_DIV);
    wire logic hit_frac = (i_addr == ADDR_PLL_FRAC);
    wire logic hit_ramp = (i_addr == ADDR_DAC_RAMP);

    // A write strobe to an unmapped address reaches no register.
    wire logic wr_div   = i_wr & hit_div;
    wire logic wr_frac  = i_wr & hit_frac;
    wire logic wr_ramp  = i_wr & hit_ramp;

    apd_regs u_regs (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_wr_div   (wr_div),
        .i_wr_frac  (wr_frac),
        .i_wr_ramp  (wr_ramp),
        .i_wdata    (i_wdata),
        .o_div      (div_reg),
        .o_frac     (frac_reg),
        .o_soft_dis (soft_dis)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits read as zero.
    wire logic [15:0] rd_div  = {div_reg.pll_on_bit, div_reg.bypass_divider, div_reg.pre_divider,
                                 div_reg.integer_multiplier, RSVD_LOW};
    wire logic [15:0] rd_frac = {frac_reg, RSVD_LOW};
    wire logic [15:0] rd_ramp = 16'h0000 | (16'(soft_dis) << POS_SOFT_DIS);

    // Read-back selection by address; unmapped addresses read zero.
    function automatic logic [15:0] apd_read_sel(input logic [7:0]  addr,
                                                 input logic [15:0] div_word,
                                                 input logic [15:0] frac_word,
                                                 input logic [15:0] ramp_word);
        case (addr)
            ADDR_PLL_DIV: begin
                apd_read_sel = div_word;
            end
            ADDR_PLL_FRAC: begin
                apd_read_sel = frac_word;
            end
            ADDR_DAC_RAMP: begin
                apd_read_sel = ramp_word;
            end
            default: begin
                apd_read_sel = 16'h0000;
            end
        endcase
    endfunction : apd_read_sel

    wire logic [15:0] next_rdata = apd_read_sel(i_addr, rd_div, rd_frac, rd_ramp);

    ////////////////////////////////////////////////////////////////////////////
    // Effective divider values, one decoder each for the bypass, pre-divider and fraction fields.
    // A zero bypass code selects the longest divide, sixteen.
    function automatic logic [4:0] apd_ratio4(input logic [3:0] code);
        apd_ratio4 = (code == 4'h0) ? DIV16 : {1'b0, code};
    endfunction : apd_ratio4

    // A zero pre-divider code selects eight.
    function automatic logic [3:0] apd_ratio3(input logic [2:0] code);
        apd_ratio3 = (code == 3'h0) ? DIV8 : {1'b0, code};
    endfunction : apd_ratio3

    // Codes above the fraction limit are replaced by the limit.
    function automatic logic [13:0] apd_clamp(input logic [13:0] code);
        apd_clamp = (code > FRAC_LIMIT) ? FRAC_LIMIT : code;
    endfunction : apd_clamp

    ////////////////////////////////////////////////////////////////////////////
    // Field selection; fields unused in the current mode show neutral values.
    wire logic        pll_on            = div_reg.pll_on_bit;
    wire logic [4:0]  bypass_code_ratio = apd_ratio4(div_reg.bypass_divider);
    wire logic [3:0]  pre_code_ratio    = apd_ratio3(div_reg.pre_divider);
    wire logic [13:0] frac_eff          = apd_clamp(frac_reg);
    wire logic [4:0]  next_bypass       = pll_on ? DIV16 : bypass_code_ratio;
    wire logic [3:0]  next_pre          = pll_on ? pre_code_ratio : DIV8;
    wire logic [5:0]  next_int          = pll_on ? div_reg.integer_multiplier : RST_INT;
    wire logic [13:0] next_frac         = pll_on ? frac_eff : RST_FRAC;
    wire logic        next_soft         = soft_dis;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers; each field has its own flop so outputs never pass logic.
    logic        cfg_pll_on;
    logic [4:0]  cfg_bypass;
    logic [3:0]  cfg_pre;
    logic [5:0]  cfg_int;
    logic [13:0] cfg_frac;
    logic        cfg_soft;

    // Read data holds until the next read.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // Read valid is a one-cycle pulse after each read strobe.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
        end
    end

    // PLL enable as seen by the clock generator.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_pll_on <= '0;
        end else begin
            cfg_pll_on <= pll_on;
        end
    end

    // Bypass divide ratio.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_bypass <= '0;
        end else begin
            cfg_bypass <= next_bypass;
        end
    end

    // Pre-divide ratio.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_pre <= '0;
        end else begin
            cfg_pre <= next_pre;
        end
    end

    // Integer multiplier.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_int <= '0;
        end else begin
            cfg_int <= next_int;
        end
    end

    // Clamped fraction multiplier.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_frac <= '0;
        end else begin
            cfg_frac <= next_frac;
        end
    end

    // Soft-step disable.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_soft <= '0;
        end else begin
            cfg_soft <= next_soft;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pack the field flops into the configuration output.
    assign o_cfg = '{cfg_pll_on,
                     cfg_bypass,
                     cfg_pre,
                     cfg_int,
                     cfg_frac,
                     cfg_soft};
endmodule : apd_top
`default_nettype wire

// >>> apd_host.sv
// Host model: register writes and reads, driven on the falling edge.
// Assumes the bench calls acc.
`default_nettype none
module apd_host (input wire logic i_clk, output logic o_wr = 1'h0, output logic o_rd = 1'h0,
    output logic [7:0] o_addr = 8'h00, output logic [15:0] o_wdata = 16'h0000);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        {o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, d & (a == 8'h1d ? 16'h4000 : 16'hfffc)};
        @(negedge i_clk);
        {o_wr, o_rd, o_wdata} <= {2'h0, ~o_wdata};
    endtask : acc
endmodule : apd_host
`default_nettype wire

// >>> apd_top_chk.sv
// Checker of apd_top ports.
// Assumes the bind below.
`default_nettype none
module apd_top_chk import apd_pkg::*; (input wire logic i_sys_clk, input wire logic i_rst_n,
    input wire logic i_wr, input wire logic i_rd, input wire logic [7:0] i_addr, input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata, input wire logic o_rvalid, input wire apd_cfg_t o_cfg);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire wd = i_wr && i_addr == ADDR_PLL_DIV;
    wire [4:0] qr = i_wdata[14:11] == 4'h0 ? DIV16 : {1'h0, i_wdata[14:11]};
    wire [3:0] pr = i_wdata[10:8] == 3'h0 ? DIV8 : {1'h0, i_wdata[10:8]};
    AST_RVALID: assert property (o_rvalid == $past(i_rd)) else $error("rvalid");
    AST_RSVD: assert property (o_rvalid |-> o_rdata[1:0] == RSVD_LOW) else $error("rsvd");
    AST_PLLON: assert property (wd |-> ##2 o_cfg.pll_on == $past(i_wdata[15], 2)) else $error("on");
    AST_BYP: assert property (wd && !i_wdata[15] |-> ##2 o_cfg.bypass_ratio == $past(qr, 2)) else $error("q");
    AST_PRE: assert property (wd && i_wdata[15] |-> ##2 o_cfg.pre_ratio == $past(pr, 2)
        && o_cfg.int_mult == $past(i_wdata[7:2], 2)) else $error("pj");
    AST_FRAC_OFF: assert property (!o_cfg.pll_on |-> o_cfg.frac_mult == RST_FRAC) else $error("frac off");
    AST_CLAMP: assert property (o_cfg.frac_mult <= FRAC_LIMIT) else $error("d");
    AST_SOFT: assert property (i_wr && i_addr == ADDR_DAC_RAMP |-> ##2
        o_cfg.soft_step_disable == $past(i_wdata[POS_SOFT_DIS], 2)) else $error("soft");
    AST_RST: assert property ($rose(i_rst_n) |=> o_cfg.bypass_ratio == 5'h02 && o_cfg.int_mult == RST_INT
        && o_cfg.pll_on == RST_PLL_ON) else $error("rst");
    cover property (wd && i_wdata[15]);
    cover property (o_cfg.frac_mult == FRAC_LIMIT);
    cover property (o_rvalid && o_rdata[14]);
endmodule : apd_top_chk
bind apd_top apd_top_chk i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cfg(o_cfg));
`default_nettype wire

// >>> apd_top_test.sv
// Bench: table and random traffic against a register model.
// Assumes apd_host drives the port.
`default_nettype none
module apd_top_test import apd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, wr, rd, rv;
    logic [7:0] a;
    logic [15:0] wd, rdat, m[4];
    logic [23:0] tv[8] = '{24'h1b0000, 24'h1c0000, 24'h1d0000, 24'h1b8004, 24'h1cffff, 24'h1c9c40, 24'h1c9c3c, 24'h1b0004};
    apd_cfg_t cfg;
    int num_errors = 0, n_tests = 0, cyc = 0;
    wire [13:0] ef = m[0][15] ? (m[1][15:2] > FRAC_LIMIT ? FRAC_LIMIT : m[1][15:2]) : 14'h0;
    always #4 clk = !clk;
    apd_host i_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(a), .o_wdata(wd));
    apd_top i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(a), .i_wdata(wd),
        .o_rdata(rdat), .o_rvalid(rv), .o_cfg(cfg));
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask : chk
    task automatic cmp_cfg(input apd_cfg_t g, input apd_cfg_t e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp_cfg
    function automatic apd_cfg_t model_cfg(input logic [15:0] d, input logic [15:0] f, input logic [15:0] r);
        int q, p, fr;
        q = d[14:11] == 4'h0 ? 16 : int'(d[14:11]);
        p = d[10:8] == 3'h0 ? 8 : int'(d[10:8]);
        fr = f[15:2] > 14'h270f ? 9999 : int'(f[15:2]);
        if (d[15]) model_cfg = '{1'h1, 5'h10, 4'(p), d[7:2], 14'(fr), r[14]};
        else model_cfg = '{1'h0, 5'(q), 4'h8, 6'h01, 14'h0000, r[14]};
    endfunction : model_cfg
    task automatic give_verdict();
        $display("%0d compared, %0d wrong", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        logic [23:0] t;
        m = '{16'h1004, 16'h0000, 16'h0000, 16'h0000};
        void'($urandom(29));
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n <= 1'h1;
        for (int i = 0; i < 72; i++) begin
            t = i < 8 ? tv[i] : {8'h1b + 8'($urandom_range(3)), 16'($urandom) | 16'h0004};
            if (i > 2) i_host.acc(1'h1, t[23:16], t[15:0]);
            if (i > 2 && t[23:16] != 8'h1e) m[t[23:16] - 8'h1b] = t[15:0] & (t[23:16] == 8'h1d ? 16'h4000 : 16'hfffc);
            @(negedge clk);
            chk(17'(cfg.frac_mult), 17'(ef));
            cmp_cfg(cfg, model_cfg(m[0], m[1], m[2]));
            i_host.acc(1'h0, t[23:16], 16'h0000);
            chk({rv, rdat}, {1'h1, m[t[23:16] - 8'h1b]});
            $display("test %0d done", i);
        end
        give_verdict();
    end
endmodule : apd_top_test
`default_nettype wire
